//--- design/tc16_defines.svh
// Constants of the 16-bit timer core: offsets, fields, resets, counts.
// Assumes a single system clock and an 8-bit CPU I/O strobe bus.
`ifndef TC16_DEFINES_SVH
`define TC16_DEFINES_SVH
`define TC16_CNT_W      16
`define TC16_FILT_LEN   4
`define TC16_ADDR_CTL_A 4'h0
`define TC16_ADDR_CTL_B 4'h1
`define TC16_ADDR_CNT_L 4'h2
`define TC16_ADDR_CNT_H 4'h3
`define TC16_ADDR_CAP_L 4'h4
`define TC16_ADDR_CAP_H 4'h5
`define TC16_ADDR_CMP_L 4'h6
`define TC16_ADDR_CMP_H 4'h7
`define TC16_ADDR_IEN   4'h8
`define TC16_ADDR_IFLG  4'h9
`define TC16_ADDR_ACMP  4'hA
`define TC16_ADDR_LAST  4'hA
`define TC16_B_FILT     7
`define TC16_B_EDGE     6
`define TC16_B_WGMH     4
`define TC16_B_CS       2
`define TC16_I_CAP      5
`define TC16_I_OVF      0
`define TC16_A_SEL      2
`define TC16_RST_BYTE   8'h00
`define TC16_RST_WORD   16'h0000
`define TC16_FLOOR      16'h0000
`define TC16_MAX        16'hFFFF
`define TC16_TOP_8      16'h00FF
`define TC16_TOP_9      16'h01FF
`define TC16_TOP_10     16'h03FF
`endif

//--- design/tc16_pkg.sv
// Types and mode decoding of the 16-bit timer core.
// Assumes tc16_defines.svh on the include path.
`include "tc16_defines.svh"
package tc16_pkg;
	typedef logic [15:0] tc16_word_t;
	typedef enum logic [3:0] {
		TC16_M_NORMAL = 4'h0, TC16_M_PC8  = 4'h1, TC16_M_PC9    = 4'h2,
		TC16_M_PC10   = 4'h3, TC16_M_CTCA = 4'h4, TC16_M_FAST8  = 4'h5,
		TC16_M_FAST9  = 4'h6, TC16_M_FAST10 = 4'h7, TC16_M_PFCI = 4'h8,
		TC16_M_PFCA   = 4'h9, TC16_M_PCI  = 4'hA, TC16_M_PCA    = 4'hB,
		TC16_M_CTCI   = 4'hC, TC16_M_RSVD = 4'hD, TC16_M_FASTI  = 4'hE,
		TC16_M_FASTA  = 4'hF
	} tc16_mode_e;
	typedef enum logic [1:0] {
		TC16_UP   = 2'b01,
		TC16_DOWN = 2'b10
	} tc16_dir_e;

	// Up/down sequence modes
	function automatic logic is_dual(input tc16_mode_e m);
		return m inside {TC16_M_PC8, TC16_M_PC9, TC16_M_PC10, TC16_M_PFCI,
			TC16_M_PFCA, TC16_M_PCI, TC16_M_PCA};
	endfunction

	// Capture register defines the ceiling
	function automatic logic icr_top(input tc16_mode_e m);
		return m inside {TC16_M_PFCI, TC16_M_PCI, TC16_M_CTCI, TC16_M_FASTI};
	endfunction

	// Wrap flag at ceiling instead of at maximum
	function automatic logic wrap_top(input tc16_mode_e m);
		return m inside {TC16_M_FAST8, TC16_M_FAST9, TC16_M_FAST10,
			TC16_M_FASTI, TC16_M_FASTA};
	endfunction

	// Ceiling of the sequence
	function automatic tc16_word_t top_of(input tc16_mode_e m,
		input tc16_word_t cmpa, input tc16_word_t cap);
		tc16_word_t t;
		t = `TC16_MAX;
		case (m)
			TC16_M_PC8, TC16_M_FAST8:   t = `TC16_TOP_8;
			TC16_M_PC9, TC16_M_FAST9:   t = `TC16_TOP_9;
			TC16_M_PC10, TC16_M_FAST10: t = `TC16_TOP_10;
			TC16_M_CTCA, TC16_M_PFCA, TC16_M_PCA, TC16_M_FASTA: t = cmpa;
			TC16_M_PFCI, TC16_M_PCI, TC16_M_CTCI, TC16_M_FASTI: t = cap;
			default: t = `TC16_MAX;
		endcase
		return t;
	endfunction
endpackage

//--- design/tc16_cap_if.sv
// Carrier between the timer core and its capture input stage.
// Assumes both ends on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface tc16_cap_if;
	logic src_sel;
	logic filt_en;
	logic edge_sel;
	logic enable;
	logic evt;
	modport core  (output src_sel, filt_en, edge_sel, enable, input evt);
	modport capin (input src_sel, filt_en, edge_sel, enable, output evt);
endinterface // tc16_cap_if
`default_nettype wire

//--- design/tc16_capin.sv
// Capture input stage: synchronise, select, filter, detect edge.
// Assumes raw pin and comparator levels asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "tc16_defines.svh"
module tc16_capin import tc16_pkg::*; #(
	parameter int FILT_LEN = `TC16_FILT_LEN
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Raw trigger sources
	input wire logic cap_pin,
	input wire logic cmp_out,
	// Core side
	tc16_cap_if.capin cap
);
	initial begin
		if (FILT_LEN < 2) $error("FILT_LEN below 2");
	end

	logic [1:0]          pin_sync_q;
	logic [1:0]          cmp_sync_q;
	logic [FILT_LEN-2:0] hist_q;
	logic                filt_q;
	logic                prev_q;
	logic                src;
	logic                det;
	logic                agree;

	// Two-stage synchronisers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pin_sync_q <= 2'h0;
			cmp_sync_q <= 2'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[0], cap_pin};
			cmp_sync_q <= {cmp_sync_q[0], cmp_out};
		end
	end

	assign src   = cap.src_sel ? cmp_sync_q[1] : pin_sync_q[1];
	assign agree = (&{hist_q, src}) | ~(|{hist_q, src});

	// Four-sample filter
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hist_q <= '0;
			filt_q <= 1'b0;
		end else begin
			hist_q <= {hist_q[FILT_LEN-3:0], src};
			if (agree) filt_q <= src;
		end
	end

	assign det = cap.filt_en ? filt_q : src;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) prev_q <= 1'b0;
		else prev_q <= det;
	end

	assign cap.evt = cap.enable
		&& (cap.edge_sel ? (det && !prev_q) : (!det && prev_q));

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_held;
		$rose(src) ##0 (cap.filt_en && src)[*4];
	endsequence
	a_filter_delay: assert property (s_held |=> filt_q)
		else $error("filter output late");
	a_filter_early: assert property (cap.filt_en && $rose(src) |=> !filt_q)
		else $error("filter output early");
	a_rise_edge: assert property (!cap.filt_en ##1 (!cap.filt_en
		&& cap.enable && cap.edge_sel && $rose(src)) |-> cap.evt)
		else $error("rising edge missed");
endmodule // tc16_capin
`default_nettype wire

//--- design/tc16_core.sv
// Top of the 16-bit timer core: counter, capture, CPU byte access.
// Assumes one-cycle read and write strobes, tick pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "tc16_defines.svh"
module tc16_core import tc16_pkg::*; #(
	parameter int CNT_W = `TC16_CNT_W
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// CPU I/O bus
	input  wire logic [3:0] bus_addr,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	output var  logic [7:0] bus_rdata_q,
	// Prescaler tick
	input  wire logic       tick_in,
	// Capture sources
	input  wire logic       cap_pin,
	input  wire logic       cmp_out,
	// Interrupt requests and acknowledge
	input  wire logic       cap_irq_ack,
	output var  logic       ovf_irq_q,
	output var  logic       cap_irq_q,
	// Sequence indications
	output var  logic       count_top_q,
	output var  logic       count_floor_q
);
	initial begin
		if (CNT_W != 16) $error("CNT_W must be 16");
	end

	tc16_cap_if cap_if ();

	tc16_mode_e  wgm_q;
	logic [2:0]  cs_q;
	logic        filt_en_q;
	logic        edge_sel_q;
	logic        acmp_sel_q;
	logic        ovf_en_q;
	logic        cap_en_q;
	logic        ovf_flag_q;
	logic        cap_flag_q;
	logic [7:0]  temp_q;
	tc16_word_t  count_q;
	tc16_word_t  cap_q;
	tc16_word_t  cmpa_q;
	tc16_dir_e   dir_q;

	tc16_word_t  cnt_d;
	tc16_dir_e   dir_d;
	tc16_word_t  top;
	logic        tick;
	logic        wrap;
	logic [10:0] hit;
	logic        wr_cnt_l;
	logic        wr_cap_l;
	logic        rd_cnt_l;
	logic        rd_cap_l;
	logic        wr_iflg;
	logic        cap_evt;

	// Address decode
	always_comb begin
		if (bus_addr <= `TC16_ADDR_LAST) begin
			hit = 11'(11'h001 << bus_addr);
		end else begin
			hit = 11'h000;
		end
	end

	assign wr_cnt_l = bus_wr && hit[`TC16_ADDR_CNT_L];
	assign wr_cap_l = bus_wr && hit[`TC16_ADDR_CAP_L] && icr_top(wgm_q);
	assign rd_cnt_l = bus_rd && hit[`TC16_ADDR_CNT_L];
	assign rd_cap_l = bus_rd && hit[`TC16_ADDR_CAP_L];
	assign wr_iflg  = bus_wr && hit[`TC16_ADDR_IFLG];

	// Configuration registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wgm_q      <= TC16_M_NORMAL;
			cs_q       <= 3'h0;
			filt_en_q  <= 1'b0;
			edge_sel_q <= 1'b0;
			acmp_sel_q <= 1'b0;
			ovf_en_q   <= 1'b0;
			cap_en_q   <= 1'b0;
		end else if (bus_wr) begin
			if (hit[`TC16_ADDR_CTL_A]) begin
				wgm_q <= tc16_mode_e'({wgm_q[3:2], bus_wdata[1:0]});
			end else if (hit[`TC16_ADDR_CTL_B]) begin
				filt_en_q  <= bus_wdata[`TC16_B_FILT];
				edge_sel_q <= bus_wdata[`TC16_B_EDGE];
				wgm_q      <= tc16_mode_e'({bus_wdata[`TC16_B_WGMH -: 2],
					wgm_q[1:0]});
				cs_q       <= bus_wdata[`TC16_B_CS -: 3];
			end else if (hit[`TC16_ADDR_IEN]) begin
				ovf_en_q <= bus_wdata[`TC16_I_OVF];
				cap_en_q <= bus_wdata[`TC16_I_CAP];
			end else if (hit[`TC16_ADDR_ACMP]) begin
				acmp_sel_q <= bus_wdata[`TC16_A_SEL];
			end
		end
	end

	assign cap_if.src_sel  = acmp_sel_q;
	assign cap_if.filt_en  = filt_en_q;
	assign cap_if.edge_sel = edge_sel_q;
	assign cap_if.enable   = !icr_top(wgm_q);
	assign cap_evt         = cap_if.evt;

	tc16_capin u_capin (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.cap_pin (cap_pin),
		.cmp_out (cmp_out),
		.cap     (cap_if.capin)
	);

	// Shared high-byte holding register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			temp_q <= `TC16_RST_BYTE;
		end else if (bus_wr && (hit[`TC16_ADDR_CNT_H]
			|| hit[`TC16_ADDR_CAP_H] || hit[`TC16_ADDR_CMP_H])) begin
			temp_q <= bus_wdata;
		end else if (rd_cnt_l) begin
			temp_q <= count_q[15:8];
		end else if (rd_cap_l) begin
			temp_q <= cap_q[15:8];
		end
	end

	// Next counter value
	always_comb begin
		top   = top_of(wgm_q, cmpa_q, cap_q);
		tick  = tick_in && (cs_q != 3'h0);
		cnt_d = count_q;
		dir_d = dir_q;
		wrap  = 1'b0;
		if (tick) begin
			if (is_dual(wgm_q)) begin
				if (dir_q == TC16_UP) begin
					if (count_q >= top) begin
						cnt_d = count_q - 16'h0001;
						dir_d = TC16_DOWN;
					end else begin
						cnt_d = count_q + 16'h0001;
					end
				end else begin
					if (count_q == `TC16_FLOOR) begin
						cnt_d = count_q + 16'h0001;
						dir_d = TC16_UP;
					end else begin
						cnt_d = count_q - 16'h0001;
					end
					wrap = (count_q == 16'h0001);
				end
			end else begin
				if (count_q == top) begin
					cnt_d = `TC16_FLOOR;
				end else begin
					cnt_d = count_q + 16'h0001;
				end
				if (wrap_top(wgm_q)) begin
					wrap = (count_q == top);
				end else begin
					wrap = (count_q == `TC16_MAX);
				end
			end
		end
		if (wr_cnt_l) begin
			cnt_d = {temp_q, bus_wdata};
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= `TC16_RST_WORD;
			dir_q   <= TC16_UP;
		end else begin
			count_q <= cnt_d;
			dir_q   <= dir_d;
		end
	end

	// Compare A word
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmpa_q <= `TC16_RST_WORD;
		end else if (bus_wr && hit[`TC16_ADDR_CMP_L]) begin
			cmpa_q <= {temp_q, bus_wdata};
		end
	end

	// Capture word and flag
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cap_q <= `TC16_RST_WORD;
		end else if (cap_evt) begin
			cap_q <= count_q;
		end else if (wr_cap_l) begin
			cap_q <= {temp_q, bus_wdata};
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cap_flag_q <= 1'b0;
		end else if (cap_evt) begin
			cap_flag_q <= 1'b1;
		end else if (cap_irq_ack || (wr_iflg && bus_wdata[`TC16_I_CAP])) begin
			cap_flag_q <= 1'b0;
		end
	end

	// Wrap flag
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ovf_flag_q <= 1'b0;
		end else if (wrap && !wr_cnt_l) begin
			ovf_flag_q <= 1'b1;
		end else if (wr_iflg && bus_wdata[`TC16_I_OVF]) begin
			ovf_flag_q <= 1'b0;
		end
	end

	// Interrupt requests and indications
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ovf_irq_q     <= 1'b0;
			cap_irq_q     <= 1'b0;
			count_top_q   <= 1'b0;
			count_floor_q <= 1'b1;
		end else begin
			ovf_irq_q     <= ovf_flag_q && ovf_en_q;
			cap_irq_q     <= cap_flag_q && cap_en_q;
			count_top_q   <= (cnt_d == top);
			count_floor_q <= (cnt_d == `TC16_FLOOR);
		end
	end

	// Read data
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata_q <= `TC16_RST_BYTE;
		end else if (bus_rd) begin
			if (hit[`TC16_ADDR_CTL_A]) begin
				bus_rdata_q <= {6'h00, wgm_q[1:0]};
			end else if (hit[`TC16_ADDR_CTL_B]) begin
				bus_rdata_q <= {filt_en_q, edge_sel_q, 1'b0, wgm_q[3:2], cs_q};
			end else if (hit[`TC16_ADDR_CNT_L]) begin
				bus_rdata_q <= count_q[7:0];
			end else if (hit[`TC16_ADDR_CNT_H] || hit[`TC16_ADDR_CAP_H]) begin
				bus_rdata_q <= temp_q;
			end else if (hit[`TC16_ADDR_CAP_L]) begin
				bus_rdata_q <= cap_q[7:0];
			end else if (hit[`TC16_ADDR_CMP_L]) begin
				bus_rdata_q <= cmpa_q[7:0];
			end else if (hit[`TC16_ADDR_CMP_H]) begin
				bus_rdata_q <= cmpa_q[15:8];
			end else if (hit[`TC16_ADDR_IEN]) begin
				bus_rdata_q <= {2'h0, cap_en_q, 4'h0, ovf_en_q};
			end else if (hit[`TC16_ADDR_IFLG]) begin
				bus_rdata_q <= {2'h0, cap_flag_q, 4'h0, ovf_flag_q};
			end else if (hit[`TC16_ADDR_ACMP]) begin
				bus_rdata_q <= {5'h00, acmp_sel_q, 2'h0};
			end else begin
				bus_rdata_q <= 8'h00;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_stop_hold: assert property (cs_q == 3'h0 && !wr_cnt_l
		|=> $stable(count_q))
		else $error("stopped counter moved");
	a_cpu_wins: assert property (wr_cnt_l && tick
		|=> count_q == {$past(temp_q), $past(bus_wdata)})
		else $error("counter write lost");
	a_temp_load: assert property (rd_cnt_l && !bus_wr
		|=> temp_q == $past(count_q[15:8]))
		else $error("holding byte not loaded");
	sequence s_cap_read;
		rd_cap_l && !bus_wr ##1 !bus_rd && !bus_wr
		##1 bus_rd && hit[`TC16_ADDR_CAP_H] && !bus_wr;
	endsequence
	a_cap_read: assert property (s_cap_read
		|=> bus_rdata_q == $past(cap_q[15:8], 3))
		else $error("capture high byte wrong");
	a_cap_copy: assert property (cap_evt
		|=> cap_q == $past(count_q) && cap_flag_q)
		else $error("capture copy missing");
	a_set_wins: assert property (cap_evt && cap_irq_ack |=> cap_flag_q)
		else $error("capture flag lost");
	a_cap_clear: assert property (!cap_evt && cap_irq_ack |=> !cap_flag_q)
		else $error("capture flag not cleared");
	a_cap_gate: assert property (bus_wr && hit[`TC16_ADDR_CAP_L]
		&& !icr_top(wgm_q) && !cap_evt |=> $stable(cap_q))
		else $error("capture written in wrong mode");
	a_no_capture: assert property (icr_top(wgm_q) |-> !cap_evt)
		else $error("capture in ceiling mode");
	a_normal_step: assert property (tick && !wr_cnt_l
		&& wgm_q == TC16_M_NORMAL |=> count_q == $past(count_q) + 16'h0001)
		else $error("normal count step wrong");
	a_normal_wrap: assert property (tick && !wr_cnt_l && wgm_q == TC16_M_NORMAL
		&& count_q == `TC16_MAX |=> ovf_flag_q ##1 (ovf_irq_q == ovf_en_q))
		else $error("wrap flag missing");
	a_floor_ind: assert property (count_q == `TC16_FLOOR |-> count_floor_q)
		else $error("floor indication missing");
endmodule // tc16_core
`default_nettype wire

//--- verif/tc16_host.sv
// Host CPU model: byte bus cycles and capture interrupt acknowledge.
// Assumes the core samples strobes on rising clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tc16_host (
	// Clock
	input  wire logic       clk_sys,
	// CPU I/O bus
	output var  logic [3:0] bus_addr,
	output var  logic       bus_wr,
	output var  logic       bus_rd,
	output var  logic [7:0] bus_wdata,
	input  wire logic [7:0] bus_rdata_q,
	// Interrupt acknowledge
	output var  logic       cap_irq_ack
);
	initial begin
		bus_addr = 4'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_wdata = 8'h00;
		cap_irq_ack = 1'b0;
	end
	// One strobed cycle, data inverted once released
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk_sys);
		bus_wr = 1'b0;
		bus_wdata = ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk_sys);
		bus_rd = 1'b0;
		d = bus_rdata_q;
	endtask
	// Word access: high first on write, low first on read
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a + 4'h1, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
	endtask
	task automatic ack();
		@(negedge clk_sys);
		cap_irq_ack = 1'b1;
		@(negedge clk_sys);
		cap_irq_ack = 1'b0;
	endtask
endmodule // tc16_host
`default_nettype wire

//--- verif/tb_top.sv
// Testbench of the 16-bit timer core driven by a host CPU model.
// Assumes tc16_pkg, tc16_core and tc16_host compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tc16_defines.svh"
module tb_top;
	logic        clk_sys;
	logic        arst_n;
	logic [3:0]  bus_addr;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_wdata;
	logic [7:0]  bus_rdata_q;
	logic        tick_in;
	logic        cap_pin;
	logic        cmp_out;
	logic        cap_irq_ack;
	logic        ovf_irq_q;
	logic        cap_irq_q;
	logic        count_top_q;
	logic        count_floor_q;
	logic [15:0] w;
	int          error_cnt = 0;
	int          num_checks = 0;

	tc16_core dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
		.tick_in(tick_in), .cap_pin(cap_pin), .cmp_out(cmp_out),
		.cap_irq_ack(cap_irq_ack), .ovf_irq_q(ovf_irq_q),
		.cap_irq_q(cap_irq_q), .count_top_q(count_top_q),
		.count_floor_q(count_floor_q));
	tc16_host host_u (.clk_sys(clk_sys), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
		.bus_rdata_q(bus_rdata_q), .cap_irq_ack(cap_irq_ack));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tk();
		@(negedge clk_sys);
		tick_in = 1'b1;
		@(negedge clk_sys);
		tick_in = 1'b0;
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge clk_sys);
	endtask
	// Cycles until capture request, 30 means none
	task automatic wait_cap(output int n);
		n = 0;
		while (cap_irq_q !== 1'b1 && n < 30) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic pin(input logic v, output int n);
		@(negedge clk_sys);
		cap_pin = v;
		wait_cap(n);
	endtask

	task automatic t_reset();
		check("floor", count_floor_q, 16'h0001);
		check("top", count_top_q, 16'h0000);
		check("irqs", {ovf_irq_q, cap_irq_q}, 16'h0000);
	endtask
	task automatic t_count();
		host_u.wr16(`TC16_ADDR_CNT_L, 16'h01FF);
		tk();
		host_u.rd16(`TC16_ADDR_CNT_L, w);
		check("stopped", w, 16'h01FF);
		check("floor", count_floor_q, 16'h0000);
		host_u.wr(`TC16_ADDR_CMP_H, 8'h55);
		host_u.wr(`TC16_ADDR_CNT_L, 8'h02);
		host_u.rd16(`TC16_ADDR_CNT_L, w);
		check("shared hold", w, 16'h5502);
		host_u.wr(4'hB, 8'hFF);
		host_u.rd(4'hB, w[7:0]);
		check("unmapped", {8'h00, w[7:0]}, 16'h0000);
	endtask
	task automatic t_normal();
		host_u.wr16(`TC16_ADDR_CNT_L, 16'hFFFE);
		host_u.wr(`TC16_ADDR_IEN, 8'h01);
		host_u.wr(`TC16_ADDR_CTL_B, 8'h01);
		tk();
		check("max", count_top_q, 16'h0001);
		tk();
		idle(1);
		check("wrap irq", ovf_irq_q, 16'h0001);
		check("floor", count_floor_q, 16'h0001);
		host_u.wr(`TC16_ADDR_IFLG, 8'h01);
		idle(1);
		check("wrap clear", ovf_irq_q, 16'h0000);
		host_u.wr(`TC16_ADDR_CNT_H, 8'h00);
		fork
			host_u.wr(`TC16_ADDR_CNT_L, 8'hFF);
			tk();
		join
		host_u.rd16(`TC16_ADDR_CNT_L, w);
		check("cpu wins", w, 16'h00FF);
		tk();
		host_u.rd16(`TC16_ADDR_CNT_L, w);
		check("count up", w, 16'h0100);
		host_u.wr(`TC16_ADDR_CTL_B, 8'h00);
	endtask
	task automatic t_dual();
		host_u.wr(`TC16_ADDR_CTL_A, 8'h01);
		host_u.wr16(`TC16_ADDR_CNT_L, 16'h00FE);
		host_u.wr(`TC16_ADDR_CTL_B, 8'h01);
		tk();
		check("ceiling", count_top_q, 16'h0001);
		tk();
		host_u.rd16(`TC16_ADDR_CNT_L, w);
		check("down", w, 16'h00FE);
		host_u.wr(`TC16_ADDR_CTL_B, 8'h00);
		host_u.wr(`TC16_ADDR_CTL_A, 8'h00);
	endtask
	task automatic t_capture();
		int n;
		host_u.wr(`TC16_ADDR_CTL_B, 8'h40);
		host_u.wr(`TC16_ADDR_IEN, 8'h20);
		host_u.wr16(`TC16_ADDR_CNT_L, 16'h1234);
		pin(1'b1, n);
		check("cap irq", cap_irq_q, 16'h0001);
		host_u.rd16(`TC16_ADDR_CAP_L, w);
		check("cap rise", w, 16'h1234);
		host_u.ack();
		idle(1);
		check("ack", cap_irq_q, 16'h0000);
		host_u.wr16(`TC16_ADDR_CNT_L, 16'h5678);
		pin(1'b0, n);
		check("no fall", 16'(n), 16'd30);
		pin(1'b1, n);
		host_u.wr16(`TC16_ADDR_CNT_L, 16'h9ABC);
		host_u.wr(`TC16_ADDR_CTL_B, 8'h00);
		host_u.wr(`TC16_ADDR_IFLG, 8'h20);
		idle(1);
		pin(1'b0, n);
		host_u.rd16(`TC16_ADDR_CAP_L, w);
		check("overwrite", w, 16'h9ABC);
	endtask
	task automatic t_filter();
		int n0;
		int n1;
		host_u.wr(`TC16_ADDR_CTL_B, 8'h40);
		host_u.wr(`TC16_ADDR_IFLG, 8'h20);
		pin(1'b1, n0);
		host_u.wr(`TC16_ADDR_IFLG, 8'h20);
		host_u.wr(`TC16_ADDR_CTL_B, 8'hC0);
		pin(1'b0, n1);
		@(negedge clk_sys);
		cap_pin = 1'b1;
		idle(3);
		cap_pin = 1'b0;
		wait_cap(n1);
		check("glitch", 16'(n1), 16'd30);
		pin(1'b1, n1);
		check("filtered", cap_irq_q, 16'h0001);
		check("delay", 16'(n1 - n0), 16'd4);
	endtask
	task automatic t_comp();
		int n;
		host_u.wr(`TC16_ADDR_CTL_B, 8'h40);
		host_u.wr(`TC16_ADDR_ACMP, 8'h04);
		host_u.wr(`TC16_ADDR_IFLG, 8'h20);
		pin(1'b0, n);
		pin(1'b1, n);
		check("pin off", 16'(n), 16'd30);
		@(negedge clk_sys);
		cmp_out = 1'b1;
		wait_cap(n);
		check("cmp cap", cap_irq_q, 16'h0001);
		host_u.wr(`TC16_ADDR_ACMP, 8'h00);
		host_u.wr(`TC16_ADDR_IFLG, 8'h20);
	endtask
	task automatic t_icr();
		int n;
		host_u.wr(`TC16_ADDR_CTL_B, 8'h58);
		host_u.wr16(`TC16_ADDR_CAP_L, 16'h0110);
		host_u.rd16(`TC16_ADDR_CAP_L, w);
		check("cap write", w, 16'h0110);
		pin(1'b0, n);
		pin(1'b1, n);
		check("cap off", 16'(n), 16'd30);
		pin(1'b0, n);
		host_u.wr(`TC16_ADDR_CTL_B, 8'h40);
		host_u.wr16(`TC16_ADDR_CAP_L, 16'h2222);
		host_u.rd16(`TC16_ADDR_CAP_L, w);
		check("cap locked", w, 16'h0110);
	endtask

	initial begin
		arst_n = 1'b0;
		tick_in = 1'b0;
		cap_pin = 1'b0;
		cmp_out = 1'b0;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		t_reset();
		t_count();
		t_normal();
		t_dual();
		t_capture();
		t_filter();
		t_comp();
		t_icr();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
